// ---- hw/imt_consts.svh ----
`ifndef IMT_CONSTS_SVH
`define IMT_CONSTS_SVH

// Register offsets
`define IMT_OFS_INT_MODE    7'h0A
`define IMT_OFS_MODE_CTL    7'h0B
`define IMT_OFS_AMP_CFG     7'h0C
`define IMT_OFS_UP_LO       7'h16
`define IMT_OFS_UP_HI       7'h17
`define IMT_OFS_LO_LO       7'h18
`define IMT_OFS_LO_HI       7'h19
`define IMT_OFS_STATUS      7'h20

// Reset values
`define IMT_RST_MODE_CTL    8'h01
`define IMT_RST_AMP_CFG     8'h00
`define IMT_RST_INT_MODE    8'h00
`define IMT_RST_THRESH      8'h00

// Field positions
`define IMT_MODE_LSB        0
`define IMT_MODE_MSB        1
`define IMT_OVERRIDE_BIT    0
`define IMT_STAT_ABOVE_BIT  3
`define IMT_STAT_WIN_BIT    2

// Values with a side effect
`define IMT_FLAG_CLEAR_VAL  8'h00

// Serial port framing
`define IMT_SPI_LAST_BIT    3'h7
`define IMT_SPI_READ_BIT    7

`endif

// ---- hw/imt_pkg.sv ----
package imt_pkg;

  typedef enum logic [1:0] {
    IMT_MODE_ACTIVE   = 2'b00,
    IMT_MODE_SLEEP    = 2'b01,
    IMT_MODE_SHUTDOWN = 2'b10,
    IMT_MODE_RESERVED = 2'b11
  } imt_functional_mode_select_t;

  typedef enum logic [1:0] {
    IMT_SPI_IDLE = 2'b00,
    IMT_SPI_CMD  = 2'b01,
    IMT_SPI_DATA = 2'b10,
    IMT_SPI_DONE = 2'b11
  } imt_spi_state_t;

endpackage

// ---- hw/imt_pin_filter.sv ----
`timescale 1ns/100ps
module imt_pin_filter
  import imt_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and control
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Pin and filtered level
  input  wire logic pin_in,
  output logic      filt
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_filt;

  // Only the later two stages are compared; the first one may be metastable
  always_comb begin
    next_stage = {stage[1:0], pin_in};
    next_filt  = (stage[2] == stage[1]) ? stage[2] : filt;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= {3{RESET_VAL}};
      filt  <= RESET_VAL;
    end else if (ce) begin
      stage <= next_stage;
      filt  <= next_filt;
    end
  end

endmodule

// ---- hw/imt_regs.sv ----
`timescale 1ns/100ps
`include "imt_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Mode field: 00 active, 01 sleep after reset, 10 shutdown, 11 reserved.
// - Entering shutdown discards all configuration back to reset values.
// - Override clear converts only when regulated; set converts regardless.
// - Upper limit is high byte at 0x17 times 256 plus low byte 0x16.
// - Active-low above-limit flag asserts when a result exceeds upper limit.
// - Upper low byte is buffered, applied only when high byte written.
// - Mode and threshold writes are accepted and applied during active mode.
// - Above-limit flag latches low; cleared by writing 0x00 to 0x0A.
// - Lower limit from 0x19 and buffered 0x18; below sets window state.
module imt_regs
  import imt_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Serial register port
  input  wire logic        spi_csn,
  input  wire logic        spi_sclk,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe,
  // Analog core interface
  input  wire logic        shutdown_permit,
  input  wire logic        amplitude_regulated,
  input  wire logic [15:0] conv_result,
  input  wire logic        conv_valid,
  // Status and control outputs
  output logic [1:0]       functional_mode_select,
  output logic             conversion_enable,
  output logic             inductance_above_limit_n,
  output logic             inductance_window_state
);

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and pin filtering

  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  logic csn_f;
  logic sclk_f;
  logic sdi_f;
  logic reg_f;

  imt_pin_filter #(.RESET_VAL(1'b1)) u_csn  (.mclk(mclk), .rst_n(rst_n), .ce(ce), .pin_in(spi_csn),  .filt(csn_f));
  imt_pin_filter #(.RESET_VAL(1'b0)) u_sclk (.mclk(mclk), .rst_n(rst_n), .ce(ce), .pin_in(spi_sclk), .filt(sclk_f));
  imt_pin_filter #(.RESET_VAL(1'b0)) u_sdi  (.mclk(mclk), .rst_n(rst_n), .ce(ce), .pin_in(spi_sdi),  .filt(sdi_f));
  imt_pin_filter #(.RESET_VAL(1'b0)) u_reg  (.mclk(mclk), .rst_n(rst_n), .ce(ce), .pin_in(amplitude_regulated),
                                             .filt(reg_f));

  function automatic logic [15:0] join_limit(input logic [7:0] hi, input logic [7:0] lo);
    join_limit = {hi, lo};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register state declarations

  logic [7:0]  mode_ctl;
  logic [7:0]  amp_cfg;
  logic [7:0]  int_mode;
  logic [7:0]  up_lo_shadow;
  logic [7:0]  up_lo;
  logic [7:0]  up_hi;
  logic [7:0]  lo_lo_shadow;
  logic [7:0]  lo_lo;
  logic [7:0]  lo_hi;
  logic        above_n;
  logic        window;
  logic [7:0]  rd_data;

  //////////////////////////////////////////////////////////////////////////////
  // Serial slave: command byte (bit 7 read, 6:0 address), then one data byte

  imt_spi_state_t spi_state;
  imt_spi_state_t next_spi_state;
  logic [2:0]     bit_cnt;
  logic [2:0]     next_bit_cnt;
  logic [6:0]     shift_in;
  logic [6:0]     next_shift_in;
  logic [7:0]     shift_out;
  logic [7:0]     next_shift_out;
  logic           is_read;
  logic           next_is_read;
  logic [6:0]     addr;
  logic [6:0]     next_addr;
  logic           sclk_q;
  logic           wr_stb;
  logic           next_wr_stb;
  logic [7:0]     wr_data;
  logic [7:0]     next_wr_data;
  logic           next_sdo;
  logic           next_sdo_oe;
  logic           sclk_rise;
  logic           sclk_fall;

  assign sclk_rise = sclk_f & ~sclk_q;
  assign sclk_fall = ~sclk_f & sclk_q;

  always_comb begin
    next_spi_state = spi_state;
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_is_read   = is_read;
    next_addr      = addr;
    next_wr_stb    = 1'b0;
    next_wr_data   = wr_data;
    next_sdo       = spi_sdo;
    next_sdo_oe    = ~csn_f;
    if (csn_f) begin
      next_spi_state = IMT_SPI_IDLE;
      next_bit_cnt   = 3'h0;
      next_sdo       = 1'b0;
    end else begin
      case (spi_state)
        IMT_SPI_IDLE: begin
          next_spi_state = IMT_SPI_CMD;
          next_bit_cnt   = 3'h0;
        end
        IMT_SPI_CMD: begin
          if (sclk_rise) begin
            next_shift_in = {shift_in[5:0], sdi_f};
            next_bit_cnt  = bit_cnt + 3'h1;
            if (bit_cnt == `IMT_SPI_LAST_BIT) begin
              next_is_read   = shift_in[6];
              next_addr      = {shift_in[5:0], sdi_f};
              next_spi_state = IMT_SPI_DATA;
            end
          end
        end
        IMT_SPI_DATA: begin
          // Read data is captured one cycle after the command completes
          if (bit_cnt == 3'h0 && !sclk_rise && !sclk_fall && sclk_f) begin
            next_shift_out = rd_data;
          end
          if (sclk_fall) begin
            next_sdo       = shift_out[7];
            next_shift_out = {shift_out[6:0], 1'b0};
          end
          if (sclk_rise) begin
            next_shift_in = {shift_in[5:0], sdi_f};
            next_bit_cnt  = bit_cnt + 3'h1;
            if (bit_cnt == `IMT_SPI_LAST_BIT) begin
              next_wr_stb    = ~is_read;
              next_wr_data   = {shift_in, sdi_f};
              next_spi_state = IMT_SPI_DONE;
            end
          end
        end
        IMT_SPI_DONE: begin
          if (sclk_fall) begin
            next_sdo = 1'b0;
          end
        end
        default: begin
          next_spi_state = IMT_SPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      spi_state  <= IMT_SPI_IDLE;
      bit_cnt    <= 3'h0;
      shift_in   <= 7'h00;
      shift_out  <= 8'h00;
      is_read    <= 1'b0;
      addr       <= 7'h00;
      sclk_q     <= 1'b0;
      wr_stb     <= 1'b0;
      wr_data    <= 8'h00;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else if (ce) begin
      spi_state  <= next_spi_state;
      bit_cnt    <= next_bit_cnt;
      shift_in   <= next_shift_in;
      shift_out  <= next_shift_out;
      is_read    <= next_is_read;
      addr       <= next_addr;
      sclk_q     <= sclk_f;
      wr_stb     <= next_wr_stb;
      wr_data    <= next_wr_data;
      spi_sdo    <= next_sdo;
      spi_sdo_oe <= next_sdo_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file, thresholds and comparison flags

  logic [7:0]     next_mode_ctl;
  logic [7:0]     next_amp_cfg;
  logic [7:0]     next_int_mode;
  logic [7:0]     next_up_lo_shadow;
  logic [7:0]     next_up_lo;
  logic [7:0]     next_up_hi;
  logic [7:0]     next_lo_lo_shadow;
  logic [7:0]     next_lo_lo;
  logic [7:0]     next_lo_hi;
  logic           next_above_n;
  logic           next_window;
  logic [1:0]     next_functional_mode_select;
  logic           next_conv_en;
  imt_functional_mode_select_t cur_mode;
  logic [1:0]     wr_mode;
  logic           conv_take;

  assign cur_mode  = imt_functional_mode_select_t'(mode_ctl[`IMT_MODE_MSB:`IMT_MODE_LSB]);
  assign wr_mode   = wr_data[`IMT_MODE_MSB:`IMT_MODE_LSB];
  assign conv_take = conv_valid && (cur_mode == IMT_MODE_ACTIVE) && conversion_enable;

  always_comb begin
    rd_data = 8'h00;
    case (addr)
      `IMT_OFS_INT_MODE: rd_data = int_mode;
      `IMT_OFS_MODE_CTL: rd_data = mode_ctl;
      `IMT_OFS_AMP_CFG:  rd_data = amp_cfg;
      `IMT_OFS_UP_LO:    rd_data = up_lo_shadow;
      `IMT_OFS_UP_HI:    rd_data = up_hi;
      `IMT_OFS_LO_LO:    rd_data = lo_lo_shadow;
      `IMT_OFS_LO_HI:    rd_data = lo_hi;
      `IMT_OFS_STATUS: begin
        rd_data[`IMT_STAT_ABOVE_BIT] = above_n;
        rd_data[`IMT_STAT_WIN_BIT]   = window;
      end
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    next_mode_ctl     = mode_ctl;
    next_amp_cfg      = amp_cfg;
    next_int_mode     = int_mode;
    next_up_lo_shadow = up_lo_shadow;
    next_up_lo        = up_lo;
    next_up_hi        = up_hi;
    next_lo_lo_shadow = lo_lo_shadow;
    next_lo_lo        = lo_lo;
    next_lo_hi        = lo_hi;
    next_above_n      = above_n;
    next_window       = window;
    // Writes land in any mode, including active
    if (wr_stb) begin
      case (addr)
        `IMT_OFS_INT_MODE: begin
          next_int_mode = wr_data;
          if (wr_data == `IMT_FLAG_CLEAR_VAL) begin
            next_above_n = 1'b1;
          end
        end
        `IMT_OFS_MODE_CTL: begin
          if (wr_mode == IMT_MODE_SHUTDOWN) begin
            // Without permission the shutdown request is dropped
            if (shutdown_permit) begin
              next_mode_ctl     = {6'h00, wr_mode};
              next_amp_cfg      = `IMT_RST_AMP_CFG;
              next_int_mode     = `IMT_RST_INT_MODE;
              next_up_lo_shadow = `IMT_RST_THRESH;
              next_up_lo        = `IMT_RST_THRESH;
              next_up_hi        = `IMT_RST_THRESH;
              next_lo_lo_shadow = `IMT_RST_THRESH;
              next_lo_lo        = `IMT_RST_THRESH;
              next_lo_hi        = `IMT_RST_THRESH;
              next_above_n      = 1'b1;
              next_window       = 1'b0;
            end
          end else if (wr_mode != IMT_MODE_RESERVED) begin
            next_mode_ctl = wr_data;
          end
        end
        `IMT_OFS_AMP_CFG: next_amp_cfg = wr_data;
        `IMT_OFS_UP_LO:   next_up_lo_shadow = wr_data;
        `IMT_OFS_UP_HI: begin
          next_up_hi = wr_data;
          next_up_lo = up_lo_shadow;
        end
        `IMT_OFS_LO_LO:   next_lo_lo_shadow = wr_data;
        `IMT_OFS_LO_HI: begin
          next_lo_hi = wr_data;
          next_lo_lo = lo_lo_shadow;
        end
        default: begin
        end
      endcase
    end
    // A result in the clear cycle still sets the flag
    if (conv_take) begin
      if (conv_result > join_limit(up_hi, up_lo)) begin
        next_above_n = 1'b0;
        next_window  = 1'b0;
      end else if (conv_result < join_limit(lo_hi, lo_lo)) begin
        next_window = 1'b1;
      end
    end
    next_functional_mode_select = next_mode_ctl[`IMT_MODE_MSB:`IMT_MODE_LSB];
    next_conv_en   = (next_functional_mode_select == IMT_MODE_ACTIVE) &&
                     (reg_f || next_amp_cfg[`IMT_OVERRIDE_BIT]);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ctl                 <= `IMT_RST_MODE_CTL;
      amp_cfg                  <= `IMT_RST_AMP_CFG;
      int_mode                 <= `IMT_RST_INT_MODE;
      up_lo_shadow             <= `IMT_RST_THRESH;
      up_lo                    <= `IMT_RST_THRESH;
      up_hi                    <= `IMT_RST_THRESH;
      lo_lo_shadow             <= `IMT_RST_THRESH;
      lo_lo                    <= `IMT_RST_THRESH;
      lo_hi                    <= `IMT_RST_THRESH;
      above_n                  <= 1'b1;
      window                   <= 1'b0;
      functional_mode_select   <= IMT_MODE_SLEEP;
      conversion_enable        <= 1'b0;
      inductance_above_limit_n <= 1'b1;
      inductance_window_state  <= 1'b0;
    end else if (ce) begin
      mode_ctl                 <= next_mode_ctl;
      amp_cfg                  <= next_amp_cfg;
      int_mode                 <= next_int_mode;
      up_lo_shadow             <= next_up_lo_shadow;
      up_lo                    <= next_up_lo;
      up_hi                    <= next_up_hi;
      lo_lo_shadow             <= next_lo_lo_shadow;
      lo_lo                    <= next_lo_lo;
      lo_hi                    <= next_lo_hi;
      above_n                  <= next_above_n;
      window                   <= next_window;
      functional_mode_select   <= next_functional_mode_select;
      conversion_enable        <= next_conv_en;
      inductance_above_limit_n <= next_above_n;
      inductance_window_state  <= next_window;
    end
  end

endmodule

// ---- testbench/imt_regs_chk.sv ----
`timescale 1ns/100ps
module imt_regs_chk
  import imt_pkg::*;
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // Observed ports
  input wire logic       spi_csn,
  input wire logic       spi_sdo_oe,
  input wire logic       conv_valid,
  input wire logic [1:0] functional_mode_select,
  input wire logic       conversion_enable,
  input wire logic       inductance_above_limit_n,
  input wire logic       inductance_window_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_mode_legal; functional_mode_select != 2'b11; endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("mode output shows reserved code");
  property p_rst_vals;
    $rose(nrst) |-> functional_mode_select == 2'b01 && inductance_above_limit_n && !conversion_enable;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs off their reset values");
  property p_conv_gate; (functional_mode_select != 2'b00)[*3] |-> !conversion_enable; endproperty
  a_conv_gate: assert property (p_conv_gate) else $error("converting outside active mode");
  property p_above_cause;
    $fell(inductance_above_limit_n) |-> $past(conv_valid) && !inductance_window_state;
  endproperty
  a_above_cause: assert property (p_above_cause) else $error("above flag set without a result");
  // A clear needs a frame, so an idle port must never release the flag
  property p_above_latch; spi_csn[*8] ##0 !inductance_above_limit_n |=> !inductance_above_limit_n; endproperty
  a_above_latch: assert property (p_above_latch) else $error("above flag released while idle");
  property p_window_cause; spi_csn[*8] ##0 $changed(inductance_window_state) |-> $past(conv_valid); endproperty
  a_window_cause: assert property (p_window_cause) else $error("window moved without a result");
  property p_window_rise; $rose(inductance_window_state) |-> $past(conv_valid) && $stable(inductance_above_limit_n);
  endproperty
  a_window_rise: assert property (p_window_rise) else $error("window rise with above change");
  property p_idle_conv;
    (functional_mode_select != 2'b00)[*3] ##0 conv_valid |=> $stable(inductance_above_limit_n);
  endproperty
  a_idle_conv: assert property (p_idle_conv) else $error("result taken outside active mode");
  property p_sdo_idle; spi_csn[*6] |-> !spi_sdo_oe; endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("data out enabled while deselected");
endmodule

// ---- testbench/imt_host.sv ----
`timescale 1ns/100ps
module imt_host (
  // Clock
  input wire logic mclk,
  // Serial pins
  output logic     csn,
  output logic     sclk,
  output logic     sdi,
  input wire logic sdo
);
  initial begin
    csn = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // Phases of 8 cycles leave room for the pin filters' lag
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(negedge mclk);
    csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = sh[i];
      repeat (8) @(negedge mclk);
      if (i < 8) rd = {rd[6:0], sdo};
      sclk = 1'b1;
      repeat (8) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge mclk);
    csn = 1'b1;
    // Released line flips so stale data cannot pass for a held bit
    sdi = ~sdi;
    repeat (8) @(negedge mclk);
  endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top
  import imt_pkg::*;
;
  logic        mclk, nrst, ce, csn, sclk, sdi, sdo, sdo_oe, permit, amp_reg, conv_valid;
  logic        conv_en, above_n, win;
  logic [1:0]  fmode;
  logic [15:0] conv_result;
  int          miscompares = 0;
  int          checks = 0;

  always #25 mclk = ~mclk;

  imt_host u_host (.mclk(mclk), .csn(csn), .sclk(sclk), .sdi(sdi), .sdo(sdo));

  imt_regs u_dut (
    .mclk(mclk), .nrst(nrst), .ce(ce), .spi_csn(csn), .spi_sclk(sclk), .spi_sdi(sdi),
    .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .shutdown_permit(permit), .amplitude_regulated(amp_reg),
    .conv_result(conv_result), .conv_valid(conv_valid), .functional_mode_select(fmode),
    .conversion_enable(conv_en), .inductance_above_limit_n(above_n), .inductance_window_state(win)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_host.xfer({1'b0, a}, d, unused);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    u_host.xfer({1'b1, a}, 8'h00, d);
    chk(nm, d, e);
  endtask

  task automatic conv(input logic [15:0] r);
    @(negedge mclk);
    conv_result = r;
    conv_valid = 1'b1;
    @(negedge mclk);
    conv_valid = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  logic [6:0] ofs [5] = '{7'h0B, 7'h0C, 7'h16, 7'h17, 7'h18};
  logic [7:0] rstv [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    permit = 1'b0;
    amp_reg = 1'b0;
    conv_result = 16'h0000;
    conv_valid = 1'b0;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    repeat (12) @(negedge mclk);
    for (int i = 0; i < 5; i++) rd(ofs[i], rstv[i], "reset value");
    wr(7'h0C, 8'h00);
    wr(7'h16, 8'h34);
    wr(7'h17, 8'h12);
    wr(7'h18, 8'h10);
    wr(7'h19, 8'h00);
    wr(7'h0B, 8'h00);
    repeat (8) @(negedge mclk);
    chk("enable unregulated", {7'h00, conv_en}, 8'h00);
    wr(7'h0C, 8'h01);
    repeat (8) @(negedge mclk);
    chk("enable override", {7'h00, conv_en}, 8'h01);
    conv(16'h1234);
    chk("above at equal", {7'h00, above_n}, 8'h01);
    conv(16'h000F);
    chk("window below", {7'h00, win}, 8'h01);
    wr(7'h16, 8'h00);
    rd(7'h16, 8'h00, "low byte buffer");
    conv(16'h1234);
    chk("buffer unapplied", {7'h00, above_n}, 8'h01);
    wr(7'h17, 8'h12);
    conv(16'h1201);
    chk("above set", {7'h00, above_n}, 8'h00);
    chk("window above", {7'h00, win}, 8'h00);
    conv(16'h0000);
    chk("above latched", {7'h00, above_n}, 8'h00);
    rd(7'h20, 8'h04, "status");
    wr(7'h0A, 8'h00);
    chk("above cleared", {7'h00, above_n}, 8'h01);
    ce = 1'b0;
    conv(16'hFFFF);
    ce = 1'b1;
    repeat (2) @(negedge mclk);
    chk("frozen by enable", {7'h00, above_n}, 8'h01);
    wr(7'h0A, 8'h08);
    rd(7'h0A, 8'h08, "source select");
    wr(7'h0B, 8'h03);
    rd(7'h0B, 8'h00, "reserved mode");
    wr(7'h0B, 8'h02);
    rd(7'h0B, 8'h00, "unpermitted shutdown");
    wr(7'h0B, 8'h01);
    conv(16'hFFFF);
    chk("sleep result", {7'h00, above_n}, 8'h01);
    permit = 1'b1;
    wr(7'h0B, 8'h02);
    chk("shutdown mode", {6'h00, fmode}, 8'h02);
    for (int i = 1; i < 5; i++) rd(ofs[i], rstv[i], "shutdown loss");
    rd(7'h0A, 8'h00, "shutdown select");
    wr(7'h0B, 8'h01);
    rd(7'h0B, 8'h01, "sleep again");
    print_verdict();
  end

  // Run needs about 8800 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end
endmodule

bind imt_regs imt_regs_chk u_chk (
  .mclk(mclk), .nrst(nrst), .spi_csn(spi_csn), .spi_sdo_oe(spi_sdo_oe), .conv_valid(conv_valid),
  .functional_mode_select(functional_mode_select), .conversion_enable(conversion_enable),
  .inductance_above_limit_n(inductance_above_limit_n), .inductance_window_state(inductance_window_state)
);
